// >>> shared/perf_pkg.sv
// Constants, field layout and event code decoding for the performance counter control block.
package perf_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h11;
  localparam logic [7:0] ADDR_CTR0 = 8'h12;
  localparam logic [7:0] ADDR_CTR1 = 8'h13;
  localparam int CTR_W = 48;
  localparam int SEL_W = 7;
  localparam int CNT_W = 2;
  localparam int SRC_N = 64;
  localparam int NUM_CTR = 2;
  localparam logic [63:0] CTRL_MASK = 64'h0000_0000_07FF_07FF;
  localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;
  localparam logic [1:0] PRIV_USER = 2'h3;
  // Field positions, indexed by counter number.
  localparam int TYPE_BIT [NUM_CTR] = '{8, 24};
  localparam int PIN_BIT [NUM_CTR] = '{9, 25};
  localparam int LOW_EN_BIT [NUM_CTR] = '{6, 22};
  localparam int USER_EN_BIT [NUM_CTR] = '{7, 23};
  localparam int SEL_HI_BIT [NUM_CTR] = '{10, 26};
  localparam int SEL_LO_BIT [NUM_CTR] = '{0, 16};

  function automatic logic [SEL_W-1:0] sel_code(input logic [63:0] ctrl, input int idx);
    sel_code = {ctrl[SEL_HI_BIT[idx]], ctrl[SEL_LO_BIT[idx] +: 6]};
  endfunction : sel_code

  function automatic logic priv_ok(input logic low_en, input logic user_en, input logic [1:0] priv);
    priv_ok = (priv == PRIV_USER) ? user_en : low_en;
  endfunction : priv_ok

  function automatic logic code_duration(input logic [SEL_W-1:0] code);
    code_duration = (code >= 7'h18 && code <= 7'h1B) || code == 7'h1F;
  endfunction : code_duration

  function automatic logic code_specific(input logic [SEL_W-1:0] code);
    code_specific = code == 7'h2B || code == 7'h2D || code == 7'h2F || code == 7'h31 || code == 7'h32;
  endfunction : code_specific

  function automatic logic code_valid(input int idx, input logic [SEL_W-1:0] code);
    logic shared_ok;
    logic own_ok;
    shared_ok = code <= 7'h0F || (code >= 7'h12 && code <= 7'h1F) || (code >= 7'h22 && code <= 7'h29);
    own_ok = code == 7'h2B || code == 7'h2D || code == 7'h2F;
    if (idx == 0) begin
      own_ok = own_ok || code == 7'h31;
    end else begin
      own_ok = own_ok || code == 7'h32;
    end
    code_valid = shared_ok || own_ok;
  endfunction : code_valid
endpackage : perf_pkg

// >>> shared/perf_ctr_if.sv
// Link between the control logic and one 48-bit counter.
interface perf_ctr_if;
  import perf_pkg::*;
  logic [CNT_W-1:0] inc_amt;
  logic load;
  logic [CTR_W-1:0] load_val;
  logic [CTR_W-1:0] value;
  logic wrap;
  modport ctl (output inc_amt, output load, output load_val, input value, input wrap);
  modport ctr (input inc_amt, input load, input load_val, output value, output wrap);
endinterface : perf_ctr_if

// >>> rtl/perf_counter_unit.sv
// One 48-bit performance counter with software preset and wrap detection.
module perf_counter_unit (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Control link
  perf_ctr_if.ctr bus
);
  import perf_pkg::*;

  logic [CTR_W-1:0] value_reg;
  logic [CTR_W:0] sum;

  assign sum = {1'b0, value_reg} + (CTR_W + 1)'(bus.inc_amt);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      value_reg <= '0;
    end else if (bus.load) begin
      value_reg <= bus.load_val;
    end else begin
      value_reg <= sum[CTR_W-1:0];
    end
  end

  // A preset in the same cycle replaces the increment, so it cannot wrap.
  assign bus.value = value_reg;
  assign bus.wrap = !bus.load && sum[CTR_W];

  wrap_zero_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    bus.wrap && bus.inc_amt == 2'h1 |=> value_reg == '0)
    else $error("counter did not wrap to zero");
endmodule : perf_counter_unit

// >>> rtl/perf_event_select.sv
// Picks one event source for a counter and forms its increment per cycle.
module perf_event_select #(
  parameter int CTR_IDX = 0
) (
  // Selection from the control register
  input wire logic [perf_pkg::SEL_W-1:0] code_in,
  input wire logic clock_mode_in,
  input wire logic count_en_in,
  // Event sources
  input wire logic [perf_pkg::SRC_N-1:0][perf_pkg::CNT_W-1:0] shared_cnt_in,
  input wire logic [perf_pkg::SRC_N-1:0][perf_pkg::CNT_W-1:0] own_cnt_in,
  // Result
  output logic [perf_pkg::CNT_W-1:0] inc_amt_out,
  output logic evt_level_out
);
  import perf_pkg::*;

  logic [CNT_W-1:0] src;

  always_comb begin
    if (CTR_IDX == 1 && code_specific(code_in)) begin
      src = own_cnt_in[code_in[5:0]];
    end else begin
      src = shared_cnt_in[code_in[5:0]];
    end
  end

  always_comb begin
    if (!count_en_in) begin
      inc_amt_out = 2'h0;
    end else if (clock_mode_in) begin
      inc_amt_out = 2'h1;
    end else if (!code_valid(CTR_IDX, code_in)) begin
      inc_amt_out = 2'h0;
    end else if (code_duration(code_in)) begin
      inc_amt_out = (src != 2'h0) ? 2'h1 : 2'h0;
    end else begin
      inc_amt_out = src;
    end
  end

  assign evt_level_out = inc_amt_out != 2'h0;
endmodule : perf_event_select

// >>> rtl/perf_counter_event_control.sv
// Control register, event selection and indicator pins for two performance counters.
module perf_counter_event_control (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Register access port
  input wire logic [7:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [63:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  // Processor state
  input wire logic [1:0] current_privilege_level_in,
  // Event sources, occurrences per cycle indexed by event code
  input wire logic [perf_pkg::SRC_N-1:0][perf_pkg::CNT_W-1:0] event_count_in,
  input wire logic [perf_pkg::SRC_N-1:0][perf_pkg::CNT_W-1:0] ctr1_alt_count_in,
  // Indicator pins
  output logic indicator_pin_zero_out,
  output logic indicator_pin_one_out
);
  import perf_pkg::*;

  logic [63:0] counter_event_control_reg;
  logic [63:0] rdata_reg;
  logic rvalid_reg;
  logic [NUM_CTR-1:0] ovf_reg;
  logic [NUM_CTR-1:0] ovf_next;
  logic [NUM_CTR-1:0] pin_reg;
  logic [NUM_CTR-1:0] pin_next;
  logic [NUM_CTR-1:0] evt_level;
  logic [NUM_CTR-1:0] clock_mode;
  logic [NUM_CTR-1:0] count_en;
  logic [NUM_CTR-1:0] pin_ovf_mode;
  logic [NUM_CTR-1:0] ctr_wr;
  logic [NUM_CTR-1:0] wrap;
  logic [SEL_W-1:0] code [NUM_CTR];
  logic [CNT_W-1:0] inc [NUM_CTR];
  logic [CTR_W-1:0] value [NUM_CTR];
  logic ctrl_wr;
  logic [63:0] rdata_next;

  perf_ctr_if ctr_bus [NUM_CTR] ();

  assign ctrl_wr = reg_wr_in && reg_addr_in == ADDR_CTRL;
  assign ctr_wr[0] = reg_wr_in && reg_addr_in == ADDR_CTR0;
  assign ctr_wr[1] = reg_wr_in && reg_addr_in == ADDR_CTR1;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_event_control_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      counter_event_control_reg <= reg_wdata_in & CTRL_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_ctr
      assign clock_mode[g] = counter_event_control_reg[TYPE_BIT[g]];
      assign pin_ovf_mode[g] = counter_event_control_reg[PIN_BIT[g]];
      assign code[g] = sel_code(counter_event_control_reg, g);
      assign count_en[g] = priv_ok(counter_event_control_reg[LOW_EN_BIT[g]],
                                   counter_event_control_reg[USER_EN_BIT[g]], current_privilege_level_in);

      perf_event_select #(
        .CTR_IDX(g)
      ) u_sel (
        .code_in(code[g]),
        .clock_mode_in(clock_mode[g]),
        .count_en_in(count_en[g]),
        .shared_cnt_in(event_count_in),
        .own_cnt_in(ctr1_alt_count_in),
        .inc_amt_out(inc[g]),
        .evt_level_out(evt_level[g])
      );

      assign ctr_bus[g].inc_amt = inc[g];
      assign ctr_bus[g].load = ctr_wr[g];
      assign ctr_bus[g].load_val = reg_wdata_in[CTR_W-1:0];
      assign value[g] = ctr_bus[g].value;
      assign wrap[g] = ctr_bus[g].wrap;

      perf_counter_unit u_ctr (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .bus(ctr_bus[g])
      );

      // The overflow mark holds until software presets the counter or rewrites the control
      // register; a wrap in that same cycle still wins so no overflow is missed.
      // sticky overflow mark
      assign ovf_next[g] = wrap[g] || (ovf_reg[g] && !ctr_wr[g] && !ctrl_wr);
      assign pin_next[g] = pin_ovf_mode[g] ? ovf_next[g] : evt_level[g];
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ovf_reg <= '0;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  // Pins are registered so they change one cycle after the event that drives them.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign indicator_pin_zero_out = pin_reg[0];
  assign indicator_pin_one_out = pin_reg[1];

  always_comb begin
    rdata_next = 64'h0;
    if (reg_addr_in == ADDR_CTRL) begin
      rdata_next = counter_event_control_reg;
    end else if (reg_addr_in == ADDR_CTR0) begin
      rdata_next = {16'h0000, value[0]};
    end else if (reg_addr_in == ADDR_CTR1) begin
      rdata_next = {16'h0000, value[1]};
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 64'h0;
    end else if (reg_rd_in) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_in;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rdata_valid_out = rvalid_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence ctrl_written_s;
    // A read normally follows a write after one idle cycle on the register port.
    ctrl_wr ##1 !ctrl_wr [*2];
  endsequence

  sequence ctrl_read_back_s;
    reg_rd_in && reg_addr_in == ADDR_CTRL && !reg_wr_in;
  endsequence

  ctrl_mask_a: assert property (ctrl_wr |=> (counter_event_control_reg & ~CTRL_MASK) == 64'h0
    && counter_event_control_reg == ($past(reg_wdata_in) & CTRL_MASK))
    else $error("control write not masked");

  ctrl_readback_a: assert property (ctrl_written_s ##0 ctrl_read_back_s |=>
    reg_rdata_valid_out && reg_rdata_out == (counter_event_control_reg & CTRL_MASK))
    else $error("control read back wrong");

  unmapped_read_a: assert property (reg_rd_in && reg_addr_in != ADDR_CTRL && reg_addr_in != ADDR_CTR0
    && reg_addr_in != ADDR_CTR1 |=> reg_rdata_valid_out && reg_rdata_out == 64'h0)
    else $error("unmapped read not zero");

  ctr_read_high_a: assert property (reg_rd_in && reg_addr_in == ADDR_CTR0 |=>
    reg_rdata_out[63:CTR_W] == 16'h0000 && reg_rdata_out[CTR_W-1:0] == $past(value[0]))
    else $error("counter read wrong");

  read_valid_a: assert property (reg_rd_in |=> reg_rdata_valid_out)
    else $error("read valid missing");

  valid_pulse_a: assert property (!reg_rd_in |=> !reg_rdata_valid_out)
    else $error("read valid without a read");

  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_chk
      sequence timer_run_s;
        clock_mode[g] && count_en[g] && !ctr_wr[g];
      endsequence

      sequence duration_hold_s;
        (!clock_mode[g] && !pin_ovf_mode[g] && count_en[g] && code_duration(code[g])
          && code_valid(g, code[g]) && !ctrl_wr && event_count_in[code[g][5:0]] != 2'h0) [*2];
      endsequence

      timer_step_a: assert property (timer_run_s |=> value[g] == $past(value[g]) + 48'h1)
        else $error("timer did not advance by one");

      priv_block_a: assert property (!count_en[g] && !ctr_wr[g] |=> $stable(value[g]))
        else $error("counter moved while blocked");

      both_enable_a: assert property (counter_event_control_reg[LOW_EN_BIT[g]]
        && counter_event_control_reg[USER_EN_BIT[g]] |-> count_en[g])
        else $error("counting still depends on privilege");

      occ_add_a: assert property (!clock_mode[g] && count_en[g] && code_valid(g, code[g])
        && !code_duration(code[g]) && !ctr_wr[g] && !(g == 1 && code_specific(code[g]))
        |=> value[g] == $past(value[g]) + 48'($past(event_count_in[code[g][5:0]])))
        else $error("occurrence count wrong");

      evt_pin_a: assert property (!pin_ovf_mode[g] && inc[g] != 2'h0 |=> pin_reg[g])
        else $error("event pin missed increment");

      dur_pin_a: assert property (duration_hold_s |=> pin_reg[g] ##0 $past(pin_reg[g]))
        else $error("duration pin dropped");

      ovf_pin_a: assert property (pin_ovf_mode[g] && wrap[g] && !ctrl_wr |=> pin_reg[g] [*1])
        else $error("overflow pin not asserted");

      bad_code_a: assert property (!clock_mode[g] && !code_valid(g, code[g]) && !pin_ovf_mode[g]
        && !ctr_wr[g] |=> $stable(value[g]) && !pin_reg[g])
        else $error("unoffered code counted");

      sequence ovf_armed_s;
        ovf_reg[g] && !ctr_wr[g] && !ctrl_wr;
      endsequence

      // The gate is checked in both privilege bands, so a swapped enable bit cannot hide.
      // gate blocks increment
      gate_off_a: assert property (!count_en[g] |-> inc[g] == 2'h0)
        else $error("increment while gated off");

      low_gate_a: assert property (current_privilege_level_in != PRIV_USER |->
        count_en[g] == counter_event_control_reg[LOW_EN_BIT[g]])
        else $error("low privilege gate wrong");

      user_gate_a: assert property (current_privilege_level_in == PRIV_USER |->
        count_en[g] == counter_event_control_reg[USER_EN_BIT[g]])
        else $error("user privilege gate wrong");

      neither_off_a: assert property (!counter_event_control_reg[LOW_EN_BIT[g]]
        && !counter_event_control_reg[USER_EN_BIT[g]] |-> !count_en[g])
        else $error("counting with both enables clear");

      dur_add_a: assert property (!clock_mode[g] && count_en[g] && code_valid(g, code[g])
        && code_duration(code[g]) && !ctr_wr[g] && event_count_in[code[g][5:0]] != 2'h0
        |=> value[g] == $past(value[g]) + 48'h1)
        else $error("duration count wrong");

      evt_pin_low_a: assert property (!pin_ovf_mode[g] && inc[g] == 2'h0 |=> !pin_reg[g])
        else $error("event pin without increment");

      pin_ovf_src_a: assert property (pin_ovf_mode[g] |=> pin_reg[g] == ovf_reg[g])
        else $error("overflow pin not from flag");

      // Overflow is sticky: only a preset or a control write drops it, and a new wrap wins.
      // wrap sets flag
      wrap_set_a: assert property (wrap[g] |=> ovf_reg[g])
        else $error("wrap did not set overflow");

      ovf_sticky_a: assert property (ovf_armed_s |=> ovf_reg[g])
        else $error("overflow flag dropped");

      ovf_clear_a: assert property ((ctr_wr[g] || ctrl_wr) && !wrap[g] |=> !ovf_reg[g])
        else $error("overflow flag not cleared");

      preset_a: assert property (ctr_wr[g] |=>
        value[g] == $past(reg_wdata_in[CTR_W-1:0]))
        else $error("counter preset lost");
    end
  endgenerate
endmodule : perf_counter_event_control

// >>> testbench/perf_event_source.sv
// Model of the event sources: pipelines, caches, bus unit and debug logic.
module perf_event_source (
  // Bench control
  input wire logic fire_in,
  input wire logic [6:0] code_a_in,
  input wire logic [6:0] code_b_in,
  // Event sources toward the block
  output logic [perf_pkg::SRC_N-1:0][perf_pkg::CNT_W-1:0] event_count_out,
  output logic [perf_pkg::SRC_N-1:0][perf_pkg::CNT_W-1:0] alt_count_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import perf_pkg::*;
  // Unselected sources run at full rate, so a wrong pick shows up as extra counts.
  always_comb begin
    for (int i = 0; i < SRC_N; i++) begin
      event_count_out[i] = 2'h0;
      alt_count_out[i] = 2'h0;
      if (fire_in) begin
        event_count_out[i] = (i == code_a_in || i == code_b_in) ? 2'h2 : 2'h3;
        alt_count_out[i] = (i == code_b_in) ? 2'h1 : 2'h3;
      end
    end
  end
endmodule : perf_event_source

// >>> testbench/perf_counter_event_control_bench.sv
// Self-checking bench for the performance counter control block.
module perf_counter_event_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import perf_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h0;
  logic [63:0] reg_wdata_in = 64'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [63:0] reg_rdata_out;
  logic reg_rdata_valid_out;
  logic [1:0] priv = 2'h0;
  logic [SRC_N-1:0][CNT_W-1:0] ev_cnt;
  logic [SRC_N-1:0][CNT_W-1:0] alt_cnt;
  logic pin0;
  logic pin1;
  logic fire = 1'b0;
  logic [6:0] code_a = 7'h0;
  logic [6:0] code_b = 7'h0;
  int num_errors = 0;
  int samples_checked = 0;
  int cycle_count = 0;
  logic [6:0] codes [30] = '{7'h00, 7'h01, 7'h03, 7'h04, 7'h12, 7'h13, 7'h14, 7'h15, 7'h18, 7'h19, 7'h1A,
    7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h2B, 7'h2D, 7'h2F, 7'h31,
    7'h32, 7'h10, 7'h2E, 7'h3C, 7'h40};

  always #25 mclk_in = ~mclk_in;

  perf_counter_event_control u_dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rdata_valid_out(reg_rdata_valid_out), .current_privilege_level_in(priv),
    .event_count_in(ev_cnt), .ctr1_alt_count_in(alt_cnt), .indicator_pin_zero_out(pin0),
    .indicator_pin_one_out(pin1)
  );

  perf_event_source u_src (
    .fire_in(fire), .code_a_in(code_a), .code_b_in(code_b), .event_count_out(ev_cnt),
    .alt_count_out(alt_cnt)
  );

  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] addr, input logic [63:0] data);
    @(negedge mclk_in);
    reg_addr_in = addr;
    reg_wdata_in = data;
    reg_wr_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [63:0] exp, input string what);
    @(negedge mclk_in);
    reg_addr_in = addr;
    reg_rd_in = 1'b1;
    // Valid stands for one cycle only, so it is looked at before the strobe drops.
    @(negedge mclk_in);
    chk({what, " valid"}, {63'h0, reg_rdata_valid_out}, 64'h1);
    chk(what, reg_rdata_out, exp);
    reg_rd_in = 1'b0;
  endtask : rd

  function automatic logic [63:0] ctl(input logic [6:0] c0, input logic [6:0] c1, input logic [1:0] en,
      input logic tmr, input logic pm0);
    ctl = {37'h0, c1[6], pm0, tmr, en[1], en[0], c1[5:0], 5'h0, c0[6], pm0, tmr, en[1], en[0], c0[5:0]};
  endfunction : ctl

  // Increment per cycle with shared sources at 2 and counter 1 own sources at 1.
  function automatic int rate(input int idx, input logic [6:0] c);
    logic ok;
    ok = c <= 7'h0F || (c >= 7'h12 && c <= 7'h1F) || (c >= 7'h22 && c <= 7'h29);
    ok = ok || c == 7'h2B || c == 7'h2D || c == 7'h2F || c == (idx == 0 ? 7'h31 : 7'h32);
    if (!ok) return 0;
    if ((c >= 7'h18 && c <= 7'h1B) || c == 7'h1F) return 1;
    if (idx == 1 && (c == 7'h2B || c == 7'h2D || c == 7'h2F || c == 7'h32)) return 1;
    return 2;
  endfunction : rate

  always @(posedge mclk_in) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    logic [1:0] pv;
    int n;
    repeat (6) @(negedge mclk_in);
    nrst_in = 1'b1;
    rd(ADDR_CTRL, 64'h0, "ctrl reset");
    rd(ADDR_CTR0, 64'h0, "ctr0 reset");
    chk("pins reset", {62'h0, pin1, pin0}, 64'h0);
    wr(ADDR_CTRL, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(ADDR_CTRL, 64'h0000_0000_07FF_07FF, "ctrl mask");
    wr(ADDR_CTRL, 64'h0);
    wr(8'h20, 64'h0000_0000_0000_0101);
    rd(ADDR_CTRL, 64'h0, "ctrl after stray");
    rd(8'h20, 64'h0, "unmapped");
    for (int e = 0; e < 4; e++) begin
      for (int j = 0; j < 2; j++) begin
        pv = (j == 0) ? 2'h1 : 2'h3;
        priv = pv;
        wr(ADDR_CTR0, 64'h0);
        wr(ADDR_CTR1, 64'h0);
        wr(ADDR_CTRL, ctl(7'h0, 7'h0, 2'(e), 1'b1, 1'b0));
        repeat (5) @(negedge mclk_in);
        wr(ADDR_CTRL, 64'h0);
        n = ((pv == 2'h3) ? e[1] : e[0]) ? 7 : 0;
        rd(ADDR_CTR0, 64'(n), "timer ctr0");
        rd(ADDR_CTR1, 64'(n), "timer ctr1");
      end
    end
    priv = 2'h0;
    for (int i = 0; i < 30; i++) begin
      code_a = codes[i];
      code_b = codes[(i + 1) % 30];
      wr(ADDR_CTR0, 64'h0);
      wr(ADDR_CTR1, 64'h0);
      wr(ADDR_CTRL, ctl(code_a, code_b, 2'h3, 1'b0, 1'b0));
      fire = 1'b1;
      repeat (2) @(negedge mclk_in);
      chk("event pin0", {63'h0, pin0}, 64'(rate(0, code_a) != 0));
      chk("event pin1", {63'h0, pin1}, 64'(rate(1, code_b) != 0));
      repeat (2) @(negedge mclk_in);
      fire = 1'b0;
      @(negedge mclk_in);
      chk("idle pins", {62'h0, pin1, pin0}, 64'h0);
      wr(ADDR_CTRL, 64'h0);
      rd(ADDR_CTR0, 64'(4 * rate(0, code_a)), "event ctr0");
      rd(ADDR_CTR1, 64'(4 * rate(1, code_b)), "event ctr1");
    end
    wr(ADDR_CTRL, ctl(7'h0, 7'h0, 2'h3, 1'b1, 1'b1));
    wr(ADDR_CTR0, 64'h0000_FFFF_FFFF_FFFD);
    chk("ovf pin early", {63'h0, pin0}, 64'h0);
    @(negedge mclk_in);
    chk("ovf pin pre", {63'h0, pin0}, 64'h0);
    repeat (4) @(negedge mclk_in);
    chk("ovf pin", {63'h0, pin0}, 64'h1);
    chk("ovf pin1 quiet", {63'h0, pin1}, 64'h0);
    rd(ADDR_CTR0, 64'h3, "wrapped ctr0");
    chk("ovf pin held", {63'h0, pin0}, 64'h1);
    wr(ADDR_CTR0, 64'h0);
    @(negedge mclk_in);
    chk("ovf pin cleared", {63'h0, pin0}, 64'h0);
    @(negedge mclk_in);
    nrst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    rd(ADDR_CTRL, 64'h0, "ctrl rereset");
    chk("pins rereset", {62'h0, pin1, pin0}, 64'h0);
    print_verdict();
  end
endmodule : perf_counter_event_control_bench
